/* File: rtl/ddr3_capture_defines.vh */
// Functional notes
// R1 - An every-edge selection captures one sample on each clock 0 rising edge, unfiltered.
// R2 - With only the first chip select active, clock enable 1 reads low and chip selects 1-3 high.
// R3 - With two chip selects active, selects 2-3 read high; with all four active none is forced.
// R4 - The default selection is first chip select only, sampled on every rising edge.
// R5 - A selective selection suppresses storage of idle bus cycles.
// R6 - In selective mode a sample is stored when row or column strobe is low with a valid select.
// R7 - After each qualified column strobe the next X cycles are stored, then storage pauses.
// R8 - A qualified column strobe inside the trailing window restarts the count at its full value.
// R9 - X equals the burst length of 8 cycles plus the selected latency limit.
// R10 - The latency limit is selectable from 5 to 25 in steps of one for every select grouping.
// R11 - Refresh cycles are stored or suppressed by an option; storing them is the default.
// R12 - The refresh suppression option is ignored under any every-edge selection.
// R13 - A refresh is select, row strobe and column strobe low with write enable high.
`ifndef DDR3_CAPTURE_DEFINES_VH
`define DDR3_CAPTURE_DEFINES_VH

// chip select groupings
`define CS_GRP_ONE        2'h0
`define CS_GRP_TWO        2'h1
`define CS_GRP_FOUR       2'h2

// clocking and refresh choices, value 0 is the default
`define CLK_EVERY_EDGE    1'h0
`define CLK_SELECTIVE     1'h1
`define REF_ACQUIRE       1'h0
`define REF_DROP          1'h1

// trailing window timing in clock cycles
`define BURST_CYCLES      6'h08
`define LAT_MIN           5'h05
`define LAT_MAX           5'h19
`define WIN_W             6

// reset values
`define WIN_RST           6'h00
`define LOST_RST          16'h0000

`endif

/* File: rtl/sample_fifo.v */
`timescale 1ns/100ps
// small first-in first-out store between qualifier and sample memory
module sample_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 2
) (
  // clock and reset
  input  wire             ref_clk_i,
  input  wire             sys_rst_i,
  // filling side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // draining side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      fill;

  wire push = in_valid_i & in_ready_o;
  wire pop  = out_valid_o & out_ready_i;

  // full and empty come straight from the fill count
  assign in_ready_o  = (fill != DEPTH[AW:0]);
  assign out_valid_o = (fill != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];

  // storage holds no reset; only valid entries are ever read
  always @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers wrap at depth so any depth works
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill   <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        fill <= fill + 1'b1;
      end else if (pop & ~push) begin
        fill <= fill - 1'b1;
      end
    end
  end

endmodule

/* File: rtl/ddr3_bus_selective_capture.v */
`timescale 1ns/100ps
`include "ddr3_capture_defines.vh"
// acquisition qualifier of a passive ddr3 bus monitor
module ddr3_bus_selective_capture #(
  parameter DQ_W    = 64,
  parameter FIFO_D  = 2
) (
  // clock (ddr clock 0 domain) and reset
  input  wire                       ref_clk_i,
  input  wire                       sys_rst_i,
  // acquisition setup
  input  wire [1:0]                 cs_group_i,
  input  wire                       selective_i,
  input  wire [4:0]                 latency_limit_i,
  input  wire                       refresh_drop_i,
  // observed ddr3 bus
  input  wire [3:0]                 cs_n_i,
  input  wire [1:0]                 cke_i,
  input  wire                       ras_n_i,
  input  wire                       cas_n_i,
  input  wire                       we_n_i,
  input  wire [2:0]                 ba_i,
  input  wire [15:0]                addr_i,
  input  wire [DQ_W-1:0]            dq_i,
  // sample stream to capture memory
  output wire                       smp_valid_o,
  input  wire                       smp_ready_i,
  output wire [DQ_W+27:0]           smp_data_o,
  // status
  output wire                       window_active_o,
  output wire [`WIN_W-1:0]          window_count_o,
  output reg                        lost_o,
  output reg  [15:0]                lost_count_o
);

  localparam SMP_W = DQ_W + 28;

  //--------------------------------------------------------------------------
  // pin synchronisers
  //--------------------------------------------------------------------------

  reg [SMP_W-1:0] pin_s1;
  reg [SMP_W-1:0] pin_s2;

  // every bus pin passes two flops before any logic looks at it
  // resetting them to ones makes the bus look deselected until real samples arrive
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pin_s1 <= {SMP_W{1'b1}};
      pin_s2 <= {SMP_W{1'b1}};
    end else begin
      pin_s1 <= {cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i, dq_i};
      pin_s2 <= pin_s1;
    end
  end

  // field split of the second stage only
  wire [1:0]      raw_cke  = pin_s2[SMP_W-1 -: 2];
  wire [3:0]      raw_cs_n = pin_s2[SMP_W-3 -: 4];
  wire            ras_n    = pin_s2[SMP_W-7];
  wire            cas_n    = pin_s2[SMP_W-8];
  wire            we_n     = pin_s2[SMP_W-9];
  wire [DQ_W+18:0] rest    = pin_s2[DQ_W+18:0];

  //--------------------------------------------------------------------------
  // forcing of unused selects and clock enable
  //--------------------------------------------------------------------------

  reg [3:0] cs_n;
  reg [1:0] cke;

  // unused ranks are pinned inactive so stray levels never qualify a cycle
  always @* begin
    cs_n = raw_cs_n;
    cke  = raw_cke;
    case (cs_group_i)
      `CS_GRP_ONE: begin
        cke[1]    = 1'b0;                                  // R2
        cs_n[3:1] = 3'h7;                                  // R2
      end
      `CS_GRP_TWO: begin
        cs_n[3:2] = 2'h3;                                  // R3
      end
      `CS_GRP_FOUR: begin
        cs_n = raw_cs_n;                                   // R3
      end
      default: begin
        cke[1]    = 1'b0;                                  // R4
        cs_n[3:1] = 3'h7;
      end
    endcase
  end

  //--------------------------------------------------------------------------
  // command qualification
  //--------------------------------------------------------------------------

  wire cs_valid    = ~&cs_n;
  wire refresh_cmd = cs_valid & ~ras_n & ~cas_n & we_n;    // R13
  wire every_edge  = (selective_i == `CLK_EVERY_EDGE);
  // refresh option only takes effect while clocking selectively
  wire drop_ref    = ~every_edge & (refresh_drop_i == `REF_DROP) & refresh_cmd; // R11 R12
  wire cmd_hit     = cs_valid & (~ras_n | ~cas_n) & ~drop_ref;                  // R6
  // a dropped refresh must not open a trailing window either
  wire cas_hit     = cs_valid & ~cas_n & ~drop_ref;                             // R7

  //--------------------------------------------------------------------------
  // trailing window
  //--------------------------------------------------------------------------

  reg  [4:0]        lat;
  reg  [`WIN_W-1:0] win_cnt;
  reg  [`WIN_W-1:0] next_win_cnt;
  reg               win_active;
  wire [`WIN_W-1:0] win_len;

  // out-of-range latency settings clamp to the nearest legal limit
  always @* begin
    if (latency_limit_i < `LAT_MIN) begin
      lat = `LAT_MIN;                                      // R10
    end else if (latency_limit_i > `LAT_MAX) begin
      lat = `LAT_MAX;                                      // R10
    end else begin
      lat = latency_limit_i;
    end
  end

  assign win_len = `BURST_CYCLES + {1'b0, lat};            // R9

  // in selective mode the count reloads on every qualified column strobe, so back-to-back commands extend it
  always @* begin
    if (every_edge) begin
      next_win_cnt = `WIN_RST;
    end else if (cas_hit) begin
      next_win_cnt = win_len;                              // R7 R8
    end else if (win_cnt != `WIN_RST) begin
      next_win_cnt = win_cnt - 1'b1;                       // R7
    end else begin
      next_win_cnt = `WIN_RST;
    end
  end

  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      win_cnt <= `WIN_RST;
    end else begin
      win_cnt <= next_win_cnt;
    end
  end

  // the flag is registered beside the count, so the status pin comes from a flop
  // and always agrees with the count it stands for
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      win_active <= 1'b0;
    end else begin
      win_active <= (next_win_cnt != `WIN_RST);            // R7
    end
  end

  assign window_active_o = win_active;
  assign window_count_o  = win_cnt;

  //--------------------------------------------------------------------------
  // store decision and capture stage
  //--------------------------------------------------------------------------

  // every-edge keeps all cycles; selective keeps commands and window only
  // the cas cycle itself is kept by cmd_hit; the window covers the cycles after it
  wire store = every_edge ? 1'b1 :                         // R1
               (cmd_hit | window_active_o);                // R5 R6 R7

  reg              cap_valid;
  reg [SMP_W-1:0]  cap_word;
  wire             fifo_ready;

  // stored word carries the forced selects, as the display expects them
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cap_valid <= 1'b0;
      cap_word  <= {SMP_W{1'b0}};
    end else begin
      cap_valid <= store;
      cap_word  <= {cke, cs_n, ras_n, cas_n, we_n, rest};
    end
  end

  //--------------------------------------------------------------------------
  // overflow accounting
  //--------------------------------------------------------------------------

  // the bus cannot be stalled, so a word meeting a full buffer is lost
  // the flag is sticky so that even a single lost word is still seen later
  wire lose = cap_valid & ~fifo_ready;

  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      lost_o       <= 1'b0;
      lost_count_o <= `LOST_RST;
    end else if (lose) begin
      lost_o       <= 1'b1;
      lost_count_o <= (lost_count_o == 16'hFFFF) ? lost_count_o : lost_count_o + 1'b1;
    end
  end

  //--------------------------------------------------------------------------
  // output buffer
  //--------------------------------------------------------------------------

  // two entries ride out a short stall by the sample memory
  sample_fifo #(
    .WIDTH (SMP_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (cap_valid),
    .in_ready_o  (fifo_ready),
    .in_data_i   (cap_word),
    .out_valid_o (smp_valid_o),
    .out_ready_i (smp_ready_i),
    .out_data_o  (smp_data_o)
  );

endmodule

/* File: verification/ddr3_capture_properties.sv */
`timescale 1ns/100ps
`include "ddr3_capture_defines.vh"
// ------
// port-level checks of the capture qualifier
// ------
module ddr3_capture_properties #(
  parameter DQ_W = 64
) (
  // clock and reset
  input logic                ref_clk_i,
  input logic                sys_rst_i,
  // setup
  input logic [1:0]          cs_group_i,
  input logic                selective_i,
  input logic [4:0]          latency_limit_i,
  input logic                refresh_drop_i,
  // observed bus
  input logic [3:0]          cs_n_i,
  input logic [1:0]          cke_i,
  input logic                ras_n_i,
  input logic                cas_n_i,
  input logic                we_n_i,
  input logic [2:0]          ba_i,
  input logic [15:0]         addr_i,
  input logic [DQ_W-1:0]     dq_i,
  // stream and status
  input logic                smp_valid_o,
  input logic                smp_ready_i,
  input logic [DQ_W+27:0]    smp_data_o,
  input logic                window_active_o,
  input logic [`WIN_W-1:0]   window_count_o,
  input logic                lost_o,
  input logic [15:0]         lost_count_o
);
  // active select mask; grouping 3 behaves as the single select
  wire [3:0] act = (cs_group_i == `CS_GRP_FOUR) ? 4'hF : (cs_group_i == `CS_GRP_TWO) ? 4'h3 : 4'h1;
  wire       sel_hit = |(~cs_n_i & act);
  wire       drop = selective_i && refresh_drop_i && !ras_n_i && !cas_n_i && we_n_i;
  wire       hit = sel_hit && (!ras_n_i || !cas_n_i) && !drop;
  wire       qcas = sel_hit && !cas_n_i && !drop;
  // out-of-range limits clamp, so the expected window clamps alike
  wire [5:0] lat = (latency_limit_i < 5'h05) ? 6'h05 :
                   (latency_limit_i > 5'h19) ? 6'h19 : {1'b0, latency_limit_i};
  wire [5:0] x_len = `BURST_CYCLES + lat;
  // pins as the stream word should carry them after forcing
  wire [1:0] cke_f = act[1] ? cke_i : {1'b0, cke_i[0]};
  wire [DQ_W+27:0] word = {cke_f, cs_n_i | ~act, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i, dq_i};
  // setup unchanged since the last edge; a change restarts the stream checks
  reg  [8:0] cfg_q;
  wire       calm = cfg_q == {cs_group_i, selective_i, latency_limit_i, refresh_drop_i};
  always @(posedge ref_clk_i) begin
    cfg_q <= {cs_group_i, selective_i, latency_limit_i, refresh_drop_i};
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_EDGE_NO_WINDOW: assert property ((!selective_i)[*4] |-> window_count_o == 6'h00)
    else $error("window count runs in every-edge mode");
  AST_WIN_LOAD: assert property (selective_i && calm && qcas |-> ##3 window_count_o == x_len)
    else $error("window not loaded with burst plus latency");
  AST_WIN_COUNT: assert property (
    selective_i && calm && window_count_o != 6'h00 && !$past(qcas, 2)
    |=> window_count_o == $past(window_count_o) - 6'h01)
    else $error("window count did not step down by one");
  AST_WIN_FLAG: assert property (window_active_o == (window_count_o != 6'h00))
    else $error("window flag disagrees with count");
  AST_EDGE_STREAM: assert property (
    (calm && !selective_i && smp_ready_i)[*6] |-> smp_valid_o && smp_data_o == $past(word, 4))
    else $error("every-edge word missing or wrongly forced");
  AST_SEL_STREAM: assert property (
    (calm && selective_i && smp_ready_i)[*6]
    |-> smp_valid_o == ($past(hit, 4) || $past(window_count_o, 2) != 6'h00))
    else $error("selective storage decision wrong");
  AST_STALL_HOLD: assert property (
    smp_valid_o && !smp_ready_i |=> smp_valid_o && $stable(smp_data_o))
    else $error("word changed while stalled");
  AST_RESET_CLEAR: assert property (disable iff (1'b0) sys_rst_i |=> !smp_valid_o &&
    window_count_o == 6'h00 && !lost_o && lost_count_o == 16'h0000)
    else $error("reset left state behind");

  // main scenarios reached
  cover property (selective_i && qcas);
  cover property ($rose(lost_o));
  cover property (selective_i && smp_valid_o && smp_ready_i);
endmodule

/* File: verification/ddr3_bus_model.sv */
`timescale 1ns/100ps
// ------
// controller side: deselect idle, one-cycle commands
// ------
module ddr3_bus_model #(
  parameter DQ_W = 64
) (
  input  wire             ref_clk_i,
  output logic [3:0]      cs_n_o,
  output logic [1:0]      cke_o,
  output logic [2:0]      cmd_o,
  output logic [2:0]      ba_o,
  output logic [15:0]     addr_o,
  output logic [DQ_W-1:0] dq_o
);
  // start deselected, both clock enables high
  initial begin
    cs_n_o = 4'hF;
    cke_o = 2'h3;
    cmd_o = 3'h7;
    ba_o = 3'h0;
    addr_o = 16'h0000;
    dq_o = '0;
  end
  // data and address never stand still, so a stale word cannot pass
  always @(negedge ref_clk_i) begin
    dq_o <= {dq_o[DQ_W-2:0], ~dq_o[DQ_W-1]};  // johnson count, changes every cycle
    addr_o <= addr_o + 16'h0001;
    ba_o <= ba_o + 3'h1;
  end
  // command {ras, cas, we} for one clock, then back to deselect
  task automatic issue(input logic [3:0] cs, input logic [2:0] cmd);
    @(negedge ref_clk_i);
    cs_n_o <= cs;
    cmd_o <= cmd;
    @(negedge ref_clk_i);
    cs_n_o <= 4'hF;
    cmd_o <= 3'h7;
  endtask
endmodule

/* File: verification/tb.sv */
`timescale 1ns/100ps
// ------
// stream bench for the capture qualifier
// ------
module tb;
  localparam DQ_W = 64;
  localparam [2:0] RD = 3'h5;
  localparam [2:0] ACT = 3'h3;
  localparam [2:0] REF = 3'h1;
  logic ref_clk_i, sys_rst_i, selective_i, refresh_drop_i, smp_ready_i;
  logic [1:0] cs_group_i;
  logic [4:0] latency_limit_i;
  wire [3:0] cs_n;
  wire [1:0] cke;
  wire [2:0] cmd, ba;
  wire [15:0] addr, lost_cnt;
  wire [DQ_W-1:0] dq;
  wire [DQ_W+27:0] smp_data;
  wire smp_valid, win_act, lost;
  wire [5:0] win_cnt;
  int fails = 0, checks_done = 0, cycles = 0, taken = 0;

  ddr3_bus_model #(.DQ_W(DQ_W)) bus (.ref_clk_i(ref_clk_i), .cs_n_o(cs_n), .cke_o(cke),
    .cmd_o(cmd), .ba_o(ba), .addr_o(addr), .dq_o(dq));
  ddr3_bus_selective_capture #(.DQ_W(DQ_W), .FIFO_D(2)) uut (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .cs_group_i(cs_group_i), .selective_i(selective_i),
    .latency_limit_i(latency_limit_i), .refresh_drop_i(refresh_drop_i), .cs_n_i(cs_n),
    .cke_i(cke), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .ba_i(ba),
    .addr_i(addr), .dq_i(dq), .smp_valid_o(smp_valid), .smp_ready_i(smp_ready_i),
    .smp_data_o(smp_data), .window_active_o(win_act), .window_count_o(win_cnt),
    .lost_o(lost), .lost_count_o(lost_cnt));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // words stored = lost while stalled plus taken while ready
  task automatic burst(input logic [3:0] cs, input logic [2:0] c, input int gap, input int exp);
    logic [15:0] lost0;
    int          took0;
    lost0 = lost_cnt;
    took0 = taken;
    bus.issue(cs, c);
    if (gap > 0) begin
      repeat (gap) @(negedge ref_clk_i);
      bus.issue(cs, c);
    end
    repeat (40) @(negedge ref_clk_i);
    check("stored words", 32'(lost_cnt - lost0) + 32'(taken - took0), 32'(exp));
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // cycle ceiling and handshake count
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (smp_valid === 1'b1 && smp_ready_i) taken <= taken + 1;
    if (cycles == 3000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    {sys_rst_i, selective_i, refresh_drop_i, smp_ready_i} = 4'hB;
    cs_group_i = 2'h0;
    latency_limit_i = 5'h05;
    repeat (8) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    check("window count", 32'(win_cnt), 32'h0);
    // every edge for each grouping, refresh drop set but ignored
    for (int g = 2; g >= 0; g--) begin
      cs_group_i = 2'(g);
      bus.issue(4'h0, REF);
      bus.issue(4'h0, RD);
      repeat (8) @(negedge ref_clk_i);
    end
    // stall: buffer fills, every further edge is a lost word
    smp_ready_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    check("word head", {23'h0, smp_data[DQ_W+27 -: 9]}, 32'h0FF);
    check("lost flag", {31'h0, lost}, 32'h1);
    burst(4'h0, REF, 0, 42);
    selective_i = 1'b1;
    refresh_drop_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    for (int g = 0; g < 3; g++) begin
      cs_group_i = 2'(g);
      latency_limit_i = 5'(5 + g * 10);
      burst(4'hE, RD, 0, 14 + g * 10);
      burst(4'hE, ACT, 0, 1);
      burst(4'hD, RD, 0, g > 0 ? 14 + g * 10 : 0);
      burst(4'h7, RD, 0, g == 2 ? 34 : 0);
    end
    // grouping code 3 acts as the single select; an over-range limit clamps to 25
    cs_group_i = 2'h3;
    latency_limit_i = 5'h1F;
    burst(4'hE, RD, 0, 34);
    burst(4'hD, RD, 0, 0);
    burst(4'hE, RD, 2, 38);
    burst(4'hE, REF, 0, 34);
    refresh_drop_i = 1'b1;
    burst(4'hE, REF, 0, 0);
    burst(4'hF, 3'h7, 0, 0);
    // drain until empty, then take a window live
    smp_ready_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    check("drained", {31'h0, smp_valid}, 32'h0);
    burst(4'hE, RD, 0, 34);
    // leaving selective mode mid-window clears the count to zero
    bus.issue(4'hE, RD);
    repeat (6) @(negedge ref_clk_i);
    // a window of 8 plus 25 has stepped down four times by now
    check("window count", 32'(win_cnt), 32'h1D);
    check("window flag", {31'h0, win_act}, 32'h1);
    selective_i = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    check("window count", 32'(win_cnt), 32'h0);
    check("window flag", {31'h0, win_act}, 32'h0);
    summarize();
  end
endmodule

bind ddr3_bus_selective_capture ddr3_capture_properties #(.DQ_W(DQ_W)) props (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .cs_group_i(cs_group_i),
  .selective_i(selective_i), .latency_limit_i(latency_limit_i),
  .refresh_drop_i(refresh_drop_i), .cs_n_i(cs_n_i), .cke_i(cke_i), .ras_n_i(ras_n_i),
  .cas_n_i(cas_n_i), .we_n_i(we_n_i), .ba_i(ba_i), .addr_i(addr_i), .dq_i(dq_i),
  .smp_valid_o(smp_valid_o), .smp_ready_i(smp_ready_i), .smp_data_o(smp_data_o),
  .window_active_o(window_active_o), .window_count_o(window_count_o), .lost_o(lost_o),
  .lost_count_o(lost_count_o));
